// File: rtl/mfc_pkg.sv
package mfc_pkg;

  // Fault cause codes, five bits: bit 4 lands in register bit 10, bits 3:0 in 3:0
  localparam logic [4:0] CODE_ALIGN      = 5'h01;
  localparam logic [4:0] CODE_TLB_MISS   = 5'h00;
  localparam logic [4:0] CODE_ICMO       = 5'h04;
  localparam logic [4:0] CODE_EXT_L1     = 5'h0C;
  localparam logic [4:0] CODE_EXT_L2     = 5'h0E;
  localparam logic [4:0] CODE_TRANS_SEC  = 5'h05;
  localparam logic [4:0] CODE_TRANS_PAGE = 5'h07;
  localparam logic [4:0] CODE_AF_SEC     = 5'h03;
  localparam logic [4:0] CODE_AF_PAGE    = 5'h06;
  localparam logic [4:0] CODE_DOM_SEC    = 5'h09;
  localparam logic [4:0] CODE_DOM_PAGE   = 5'h0B;
  localparam logic [4:0] CODE_PERM_SEC   = 5'h0D;
  localparam logic [4:0] CODE_PERM_PAGE  = 5'h0F;
  localparam logic [4:0] CODE_EXT_PREC   = 5'h08;
  localparam logic [4:0] CODE_EXT_IMPREC = 5'h16;
  // Reserved: parity exceptions are not supported, so this is never produced
  localparam logic [4:0] CODE_PARITY     = 5'h18;
  localparam logic [4:0] CODE_DEBUG      = 5'h02;

  // Check-time fault sources, index 0 has the highest priority
  localparam int NUM_SRC = 11;
  localparam logic [NUM_SRC-1:0][4:0] SRC_CODE = {
    CODE_PERM_PAGE, CODE_PERM_SEC, CODE_DOM_PAGE, CODE_DOM_SEC,
    CODE_AF_PAGE, CODE_AF_SEC, CODE_TRANS_PAGE, CODE_TRANS_SEC,
    CODE_EXT_L2, CODE_EXT_L1, CODE_ALIGN};
  // Sources whose domain field is meaningful
  localparam logic [NUM_SRC-1:0] SRC_DOM_VALID = 11'h7F4;

  // Fault cause register field positions
  localparam int FC_CODE_HI_BIT = 10;
  localparam int FC_EXT_BIT     = 12;
  localparam int FC_DOM_LSB     = 4;

  // Descriptor field positions
  localparam int DESC_TYPE_LSB  = 0;
  localparam int DESC_DOM_LSB   = 5;
  localparam int L1_AF_BIT      = 10;
  localparam int L2_AF_BIT      = 4;
  localparam logic [1:0] DESC_FAULT    = 2'h0;
  localparam logic [1:0] DESC_COARSE   = 2'h1;
  localparam logic [1:0] DESC_RESERVED = 2'h3;
  localparam logic [1:0] DOM_CLIENT    = 2'h1;

  // Register selects of the fault record port
  localparam logic [2:0] SEL_DATA_CAUSE  = 3'h0;
  localparam logic [2:0] SEL_FETCH_CAUSE = 3'h1;
  localparam logic [2:0] SEL_DATA_LOC    = 3'h2;
  localparam logic [2:0] SEL_FETCH_LOC   = 3'h3;
  localparam logic [2:0] SEL_WATCH_LOC   = 3'h4;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // World index of the banked copies
  localparam int WORLD_NS = 0;
  localparam int WORLD_S  = 1;

endpackage

// File: rtl/mfc_prio.sv
`timescale 1ns/1ps
module mfc_prio #(
  parameter int N = 11
) (
  input  wire logic [N-1:0]         req,
  output logic                      any,
  output logic [$clog2(N)-1:0]      idx
);

  // Lowest index wins; scanning downward lets the last hit stand
  always_comb begin
    any = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = ($clog2(N))'(i);
      end
    end
  end

endmodule

// File: rtl/mfc_fault_unit.sv
`timescale 1ns/1ps
// Behaviour
// - A detected fault aborts before any external transaction; faulting access never issued.
// - Alignment checks follow the per-world enable, regardless of translation being on.
// - Translation, access flag, domain, permission faults only while translation is on.
// - A violation cancels the external access and returns an abort to the core.
// - Section translation fault on disabled walk or first-level type 00 or 11.
// - Page translation fault when second-level descriptor type is 00.
// - Access flag checks need both flag enable and extended format select set.
// - Flag zero on a loaded descriptor faults, section or page; never set by hardware.
// - Enable changes act at once, also on hits of older cached entries.
// - Access flag enable is banked per world; current world copy is used.
// - Domain entry bit 0 clear raises section or page domain fault.
// - Client domain checks permissions; failure raises section or page permission fault.
// - Debug aborts follow access completion and record the debug event code.
// - Watchpoints load the watch hit location; abort may be imprecise.
// - Cause code sits in bits 10 and 3:0, chosen by fixed priority.
// - Walk external aborts code by level; bit 12 marks slave versus decode error.
// - Translation faults code section or page; section has no valid domain.
// - Access flag faults code section or page with valid domain.
// - The parity fault code is never generated.
// - Data maintenance translation abort: data abort, data cause, both locations.
// - Instruction maintenance abort: data cause maintenance code, fetch cause the reason.
// - Fetch faults raise precise prefetch abort, fetch records only, data untouched.
// - Data external aborts update data cause; trap forces secure copies.
module mfc_fault_unit (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Controls; the two-bit ones are banked, index 1 is the secure copy
  input  wire logic [1:0]  mmu_enable,
  input  wire logic [1:0]  alignment_check_enable,
  input  wire logic [1:0]  access_flag_enable,
  input  wire logic [1:0]  extended_format_select,
  input  wire logic [1:0]  walk_disable_lower,
  input  wire logic [1:0]  walk_disable_upper,
  input  wire logic        external_abort_trap,
  input  wire logic        monitor_debug_enable,
  input  wire logic [31:0] domain_access_control,
  // Lookup result of one access
  input  wire logic        chk_valid,
  input  wire logic        chk_fetch,
  input  wire logic        chk_secure,
  input  wire logic        chk_dcache_maint,
  input  wire logic        chk_icache_maint,
  input  wire logic [31:0] chk_addr,
  input  wire logic [31:0] chk_instr_addr,
  input  wire logic        chk_misaligned,
  input  wire logic        chk_walk_needed,
  input  wire logic        chk_walk_upper,
  input  wire logic [31:0] chk_l1_desc,
  input  wire logic [31:0] chk_l2_desc,
  input  wire logic        chk_walk_abort,
  input  wire logic        chk_walk_abort_l2,
  input  wire logic        chk_walk_slverr,
  input  wire logic        chk_perm_fail,
  // Completion of an issued access
  input  wire logic        done_valid,
  input  wire logic        done_fetch,
  input  wire logic        done_secure,
  input  wire logic [31:0] done_addr,
  input  wire logic        done_ext_error,
  input  wire logic        done_precise,
  input  wire logic        done_slverr,
  input  wire logic        done_breakpoint,
  input  wire logic        done_watchpoint,
  // Fault record port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_secure,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  // To memory and core
  output logic             mem_issue,
  output logic [31:0]      mem_issue_addr,
  output logic             abort_data,
  output logic             abort_prefetch,
  output logic             abort_imprecise
);

  typedef struct packed {
    logic [1:0][31:0] data_fault_cause;
    logic [1:0][31:0] fetch_fault_cause;
    logic [1:0][31:0] data_fault_location;
    logic [1:0][31:0] fetch_fault_location;
    logic [31:0]      watch_hit_location;
    logic [31:0]      rdata;
    logic             issue;
    logic [31:0]      issue_addr;
    logic             ab_data;
    logic             ab_prefetch;
    logic             ab_imprecise;
  } mfc_state_t;

  mfc_state_t st;
  mfc_state_t next_st;

  localparam int IDX_W = $clog2(mfc_pkg::NUM_SRC);

  logic                        w;
  logic                        on;
  logic                        walk_blocked;
  logic                        walk_done;
  logic                        is_page;
  logic [1:0]                  l1_type;
  logic [1:0]                  l2_type;
  logic [3:0]                  dom_idx;
  logic [1:0]                  dom_bits;
  logic                        af_active;
  logic [mfc_pkg::NUM_SRC-1:0] src;
  logic                        flt_any;
  logic [IDX_W-1:0]            flt_idx;
  logic [4:0]                  flt_code;
  logic                        flt_ext;

  always_comb begin
    w            = chk_secure;
    on           = mmu_enable[w];
    l1_type      = chk_l1_desc[mfc_pkg::DESC_TYPE_LSB +: 2];
    l2_type      = chk_l2_desc[mfc_pkg::DESC_TYPE_LSB +: 2];
    is_page      = (l1_type == mfc_pkg::DESC_COARSE);
    dom_idx      = chk_l1_desc[mfc_pkg::DESC_DOM_LSB +: 4];
    dom_bits     = domain_access_control[{dom_idx, 1'b0} +: 2];
    // Table walk disable picks the bit of the base register in use
    walk_blocked = chk_walk_needed &&
                   (chk_walk_upper ? walk_disable_upper[w] : walk_disable_lower[w]);
    walk_done    = chk_walk_needed && !walk_blocked && !chk_walk_abort;
    // Live enables, so a cached entry with a clear flag faults too
    af_active    = access_flag_enable[w] && extended_format_select[w];
    src = '0;
    src[0]  = alignment_check_enable[w] && chk_misaligned;
    src[1]  = on && chk_walk_abort && !chk_walk_abort_l2;
    src[2]  = on && chk_walk_abort && chk_walk_abort_l2;
    src[3]  = on && (walk_blocked || (walk_done &&
              (l1_type == mfc_pkg::DESC_FAULT ||
               l1_type == mfc_pkg::DESC_RESERVED)));
    src[4]  = on && walk_done && is_page && l2_type == mfc_pkg::DESC_FAULT;
    src[5]  = on && af_active && !is_page && !chk_l1_desc[mfc_pkg::L1_AF_BIT];
    src[6]  = on && af_active && is_page && !chk_l2_desc[mfc_pkg::L2_AF_BIT];
    src[7]  = on && !is_page && !dom_bits[0];
    src[8]  = on && is_page && !dom_bits[0];
    src[9]  = on && !is_page && dom_bits == mfc_pkg::DOM_CLIENT && chk_perm_fail;
    src[10] = on && is_page && dom_bits == mfc_pkg::DOM_CLIENT && chk_perm_fail;
    flt_code = mfc_pkg::SRC_CODE[flt_idx];
    flt_ext  = (flt_idx == IDX_W'(1) || flt_idx == IDX_W'(2)) && chk_walk_slverr;
  end

  mfc_prio #(
    .N(mfc_pkg::NUM_SRC)
  ) u_prio (
    .req(src),
    .any(flt_any),
    .idx(flt_idx)
  );

  // Packs a cause code into the register layout
  function automatic logic [31:0] cause_word(input logic [4:0] code, input logic ext,
                                              input logic dv, input logic [3:0] dom);
    logic [31:0] v;
    v = mfc_pkg::RESET_WORD;
    v[3:0] = code[3:0];
    v[mfc_pkg::FC_CODE_HI_BIT] = code[4];
    v[mfc_pkg::FC_EXT_BIT] = ext;
    if (dv) begin
      v[mfc_pkg::FC_DOM_LSB +: 4] = dom;
    end
    return v;
  endfunction

  logic [31:0] chk_word;
  logic        cw;
  logic        dw;
  logic        dbg_hit;
  logic [4:0]  done_code;
  logic        cr;

  always_comb begin
    chk_word = cause_word(flt_code, flt_ext, mfc_pkg::SRC_DOM_VALID[flt_idx], dom_idx);
    // Walk external aborts go to the secure copies while trapped
    cw  = (chk_walk_abort && external_abort_trap) ? 1'b1 : chk_secure;
    dw  = (done_ext_error && external_abort_trap) ? 1'b1 : done_secure;
    dbg_hit   = monitor_debug_enable && (done_breakpoint || done_watchpoint);
    done_code = done_ext_error ? (done_precise ? mfc_pkg::CODE_EXT_PREC
                                               : mfc_pkg::CODE_EXT_IMPREC)
                               : mfc_pkg::CODE_DEBUG;
    cr = reg_secure;
  end

  always_comb begin
    next_st = st;
    next_st.issue        = 1'b0;
    next_st.ab_data      = 1'b0;
    next_st.ab_prefetch  = 1'b0;
    next_st.ab_imprecise = 1'b0;

    // Software writes first, so a hardware record in the same cycle wins
    if (reg_wr) begin
      case (reg_sel)
        mfc_pkg::SEL_DATA_CAUSE:  next_st.data_fault_cause[cr]     = reg_wdata;
        mfc_pkg::SEL_FETCH_CAUSE: next_st.fetch_fault_cause[cr]    = reg_wdata;
        mfc_pkg::SEL_DATA_LOC:    next_st.data_fault_location[cr]  = reg_wdata;
        mfc_pkg::SEL_FETCH_LOC:   next_st.fetch_fault_location[cr] = reg_wdata;
        mfc_pkg::SEL_WATCH_LOC:   next_st.watch_hit_location       = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_sel)
        mfc_pkg::SEL_DATA_CAUSE:  next_st.rdata = st.data_fault_cause[cr];
        mfc_pkg::SEL_FETCH_CAUSE: next_st.rdata = st.fetch_fault_cause[cr];
        mfc_pkg::SEL_DATA_LOC:    next_st.rdata = st.data_fault_location[cr];
        mfc_pkg::SEL_FETCH_LOC:   next_st.rdata = st.fetch_fault_location[cr];
        mfc_pkg::SEL_WATCH_LOC:   next_st.rdata = st.watch_hit_location;
        default:                  next_st.rdata = mfc_pkg::RESET_WORD;
      endcase
    end

    // Completion: external errors and debug events, only after the access finished
    if (done_valid && (done_ext_error || dbg_hit)) begin
      if (done_fetch) begin
        next_st.fetch_fault_cause[dw] = cause_word(done_code,
                                        done_ext_error && done_slverr, 1'b0, 4'h0);
        if (done_ext_error) begin
          next_st.fetch_fault_location[dw] = done_addr;
        end
        next_st.ab_prefetch = 1'b1;
      end else begin
        next_st.data_fault_cause[dw] = cause_word(done_code,
                                       done_ext_error && done_slverr, 1'b0, 4'h0);
        // An imprecise external abort has no usable address, so it reads as zero
        next_st.data_fault_location[dw] = (done_ext_error && !done_precise) ?
                                          mfc_pkg::RESET_WORD : done_addr;
        if (!done_ext_error && done_watchpoint) begin
          next_st.watch_hit_location = done_addr;
        end
        next_st.ab_data      = 1'b1;
        next_st.ab_imprecise = done_ext_error ? !done_precise : done_watchpoint;
      end
    end

    // Check: a fault holds back the external access and aborts instead
    if (chk_valid) begin
      if (!flt_any) begin
        next_st.issue      = 1'b1;
        next_st.issue_addr = chk_addr;
      end else if (chk_icache_maint) begin
        next_st.data_fault_cause[cw] = cause_word(mfc_pkg::CODE_ICMO, 1'b0, 1'b0, 4'h0);
        next_st.fetch_fault_cause[cw]    = chk_word;
        next_st.data_fault_location[cw]  = chk_addr;
        next_st.fetch_fault_location[cw] = chk_instr_addr;
        next_st.ab_data = 1'b1;
      end else if (chk_dcache_maint) begin
        next_st.data_fault_cause[cw]     = chk_word;
        next_st.data_fault_location[cw]  = chk_addr;
        next_st.fetch_fault_location[cw] = chk_instr_addr;
        next_st.ab_data = 1'b1;
      end else if (chk_fetch) begin
        next_st.fetch_fault_cause[cw]    = chk_word;
        next_st.fetch_fault_location[cw] = chk_addr;
        next_st.ab_prefetch = 1'b1;
      end else begin
        next_st.data_fault_cause[cw]    = chk_word;
        next_st.data_fault_location[cw] = chk_addr;
        next_st.ab_data = 1'b1;
      end
      if (flt_any) begin
        next_st.ab_imprecise = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st.data_fault_cause     <= {2{mfc_pkg::RESET_WORD}};
      st.fetch_fault_cause    <= {2{mfc_pkg::RESET_WORD}};
      st.data_fault_location  <= {2{mfc_pkg::RESET_WORD}};
      st.fetch_fault_location <= {2{mfc_pkg::RESET_WORD}};
      st.watch_hit_location   <= mfc_pkg::RESET_WORD;
      st.rdata                <= mfc_pkg::RESET_WORD;
      st.issue                <= 1'b0;
      st.issue_addr           <= mfc_pkg::RESET_WORD;
      st.ab_data              <= 1'b0;
      st.ab_prefetch          <= 1'b0;
      st.ab_imprecise         <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata       = st.rdata;
  assign mem_issue       = st.issue;
  assign mem_issue_addr  = st.issue_addr;
  assign abort_data      = st.ab_data;
  assign abort_prefetch  = st.ab_prefetch;
  assign abort_imprecise = st.ab_imprecise;

endmodule

// File: bench/mfc_checker.sv
`timescale 1ns/1ps
module mfc_checker (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [1:0]  mmu_enable,
  input wire logic [1:0]  alignment_check_enable,
  input wire logic [1:0]  walk_disable_lower,
  input wire logic        monitor_debug_enable,
  input wire logic        chk_valid,
  input wire logic        chk_fetch,
  input wire logic        chk_secure,
  input wire logic [31:0] chk_addr,
  input wire logic        chk_misaligned,
  input wire logic        chk_walk_needed,
  input wire logic        chk_walk_upper,
  input wire logic        done_valid,
  input wire logic        done_fetch,
  input wire logic        done_ext_error,
  input wire logic        done_watchpoint,
  input wire logic        mem_issue,
  input wire logic [31:0] mem_issue_addr,
  input wire logic        abort_data,
  input wire logic        abort_prefetch,
  input wire logic        abort_imprecise
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_misalign;
    chk_valid && !chk_fetch && chk_misaligned && alignment_check_enable[chk_secure];
  endsequence
  sequence s_untranslated;
    chk_valid && !mmu_enable[chk_secure] && !(chk_misaligned && alignment_check_enable[chk_secure]);
  endsequence
  sequence s_walk_blocked;
    chk_valid && mmu_enable[chk_secure] && chk_walk_needed && !chk_walk_upper
      && walk_disable_lower[chk_secure];
  endsequence
  AST_ALIGN_ABORT: assert property (s_misalign |=> abort_data && !mem_issue)
    else $error("misaligned access not aborted");
  AST_UNTRANSLATED_PASS: assert property (s_untranslated |=>
    mem_issue && mem_issue_addr == $past(chk_addr)) else $error("untranslated access lost");
  AST_WALK_BLOCKED: assert property (s_walk_blocked |=>
    !mem_issue && (abort_data || abort_prefetch)) else $error("blocked walk not aborted");
  AST_ISSUE_CAUSE: assert property (mem_issue |-> $past(chk_valid))
    else $error("issue without a lookup");
  AST_WATCH_ABORT: assert property (done_valid && done_watchpoint && !done_fetch
    && monitor_debug_enable |=> abort_data && abort_imprecise) else $error("watch abort lost");
  AST_DEBUG_QUIET: assert property (done_valid && !done_ext_error && !chk_valid
    && !monitor_debug_enable |=> !abort_data && !abort_prefetch) else $error("stray abort");
  AST_PREFETCH_SIDE: assert property (abort_prefetch |->
    ($past(chk_valid) && $past(chk_fetch)) || ($past(done_valid) && $past(done_fetch)))
    else $error("prefetch abort from data side");
  AST_IMPRECISE_DATA: assert property (abort_imprecise |-> abort_data)
    else $error("imprecise flag without data abort");
endmodule

// File: bench/mfc_mem_model.sv
`timescale 1ns/1ps
module mfc_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_issue,
  input  wire logic [31:0] mem_issue_addr,
  input  wire logic [6:0]  ev,
  input  wire logic [1:0]  lat,
  output logic             done_valid,
  output logic             done_fetch,
  output logic             done_secure,
  output logic             done_watchpoint,
  output logic             done_breakpoint,
  output logic             done_slverr,
  output logic             done_precise,
  output logic             done_ext_error,
  output logic [31:0]      done_addr
);
  logic [31:0] held = 32'h0;
  int          wait_n = -1;
  initial begin
    {done_valid, done_addr} = 33'h0;
    {done_fetch, done_secure, done_watchpoint, done_breakpoint} = 4'h0;
    {done_slverr, done_precise, done_ext_error} = 3'h0;
  end
  // One access in flight; idle qualifiers carry junk so the block must gate on done_valid
  always @(posedge core_clk) begin
    if (mem_issue) begin
      held   = mem_issue_addr;
      wait_n = lat;
    end
    done_valid <= (wait_n == 0);
    done_addr  <= (wait_n == 0) ? held : ~held;
    {done_fetch, done_secure, done_watchpoint, done_breakpoint, done_slverr, done_precise,
      done_ext_error} <= (wait_n == 0) ? ev : ~ev;
    if (wait_n >= 0) wait_n = wait_n - 1;
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        rd_d = 1'b0;
  logic [1:0]  mmu_enable, alignment_check_enable, access_flag_enable, extended_format_select;
  logic [1:0]  walk_disable_lower, walk_disable_upper, lat;
  logic        external_abort_trap, monitor_debug_enable, chk_valid, chk_fetch, chk_secure;
  logic        chk_dcache_maint, chk_icache_maint, chk_misaligned, chk_walk_needed;
  logic        chk_walk_upper, chk_walk_abort, chk_walk_abort_l2, chk_walk_slverr, chk_perm_fail;
  logic        done_valid, done_fetch, done_secure, done_ext_error, done_precise;
  logic        done_slverr, done_breakpoint, done_watchpoint, reg_wr, reg_rd, reg_secure;
  logic        mem_issue, abort_data, abort_prefetch, abort_imprecise;
  logic [31:0] domain_access_control, chk_addr, chk_instr_addr, chk_l1_desc, chk_l2_desc;
  logic [31:0] done_addr, reg_wdata, reg_rdata, mem_issue_addr, a, b, got;
  logic [2:0]  reg_sel;
  logic [6:0]  ev;
  logic [31:0] note[$];
  int          mismatches = 0;
  int          checked = 0;
  int          seed = 43;

  mfc_fault_unit mfc_fault_unit_inst (.*);
  mfc_mem_model mfc_mem_model_inst (.core_clk(core_clk), .mem_issue(mem_issue),
    .mem_issue_addr(mem_issue_addr), .ev(ev), .lat(lat), .done_valid(done_valid),
    .done_fetch(done_fetch), .done_secure(done_secure), .done_watchpoint(done_watchpoint),
    .done_breakpoint(done_breakpoint), .done_slverr(done_slverr), .done_precise(done_precise),
    .done_ext_error(done_ext_error), .done_addr(done_addr));

  always #4 core_clk = ~core_clk;

  function automatic logic [31:0] cw(input logic [4:0] c, input logic [3:0] d, input logic e);
    return {19'h0, e, 1'h0, c[4], 2'h0, d, c[3:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Lookup held one cycle, then one idle cycle so no input is driven twice in a step
  task automatic go(input logic [2:0] ab);
    a = $random(seed);
    b = chk_fetch ? a : $random(seed);
    {chk_addr, chk_instr_addr, chk_valid} = {a, b, 1'b1};
    note.push_back(ab == 3'h0 ? a : {29'h0, ab});
    tick(1);
    chk_valid = 1'b0;
    tick(1);
  endtask
  task automatic rg(input logic w, input logic [2:0] s, input logic sec, input logic [31:0] d);
    {reg_wr, reg_rd, reg_sel, reg_secure, reg_wdata} = {w, !w, s, sec, d};
    if (!w) note.push_back(d);
    tick(1);
    {reg_wr, reg_rd} = 2'h0;
    tick(1);
  endtask
  task automatic wrap_up();
    if (note.size() != 0) mismatches++;
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (rd_d || mem_issue || abort_data || abort_prefetch) begin
      got = rd_d ? reg_rdata : mem_issue ? mem_issue_addr
        : {29'h0, abort_imprecise, abort_prefetch, abort_data};
      checked++;
      if (note.size() == 0 || got !== note[0]) begin
        mismatches++;
        $display("mismatch at %0t: got %h expected %h", $time, got, note.size() ? note[0] : 0);
      end
      if (note.size() != 0) void'(note.pop_front());
    end
    rd_d = reg_rd;
  end

  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  initial begin
    {mmu_enable, alignment_check_enable, access_flag_enable, extended_format_select} = 8'hF0;
    {walk_disable_lower, walk_disable_upper, lat, ev, reg_sel, reg_wdata} = '0;
    {external_abort_trap, monitor_debug_enable, chk_valid, chk_fetch, chk_secure} = 5'h0;
    {chk_dcache_maint, chk_icache_maint, chk_misaligned, chk_walk_needed, chk_walk_upper} = 5'h0;
    {chk_walk_abort, chk_walk_abort_l2, chk_walk_slverr, chk_perm_fail} = 4'h0;
    {reg_wr, reg_rd, reg_secure, chk_addr, chk_instr_addr} = '0;
    {domain_access_control, chk_l1_desc, chk_l2_desc} = {32'hFFFF_FFFF, 32'h402, 32'h12};
    tick(12);
    resetn = 1'b1;
    for (int s = 0; s < 5; s++) rg(0, s[2:0], 0, 32'h0);
    go(3'h0);
    {mmu_enable, chk_misaligned} = 3'h1;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_ALIGN, 4'h0, 0));
    rg(0, 3'h2, 0, a);
    alignment_check_enable = 2'h2;
    go(3'h0);
    {chk_misaligned, chk_l1_desc} = 33'h0;
    go(3'h0);
    {alignment_check_enable, mmu_enable, chk_walk_needed, walk_disable_lower} = 7'h3D;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_TRANS_SEC, 4'h0, 0));
    chk_misaligned = 1'b1;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_ALIGN, 4'h0, 0));
    {chk_misaligned, chk_walk_upper, chk_l1_desc} = {2'h1, 32'h402};
    go(3'h0);
    {chk_l1_desc, chk_l2_desc} = {32'h1, 32'h0};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_TRANS_PAGE, 4'h0, 0));
    chk_l1_desc = 32'h3;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_TRANS_SEC, 4'h0, 0));
    {chk_walk_needed, chk_l1_desc, chk_l2_desc} = {1'b0, 32'h22, 32'h12};
    {access_flag_enable, extended_format_select} = 4'h7;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_AF_SEC, 4'h1, 0));
    chk_secure = 1'b1;
    go(3'h0);
    {chk_secure, extended_format_select} = 3'h2;
    go(3'h0);
    extended_format_select = 2'h3;
    go(3'h1);
    {chk_l1_desc, chk_l2_desc} = {32'h21, 32'h2};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_AF_PAGE, 4'h1, 0));
    {access_flag_enable, domain_access_control} = {2'h0, 32'hFFFF_FF3F};
    {chk_l1_desc, chk_l2_desc} = {32'h462, 32'h12};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_DOM_SEC, 4'h3, 0));
    mmu_enable = 2'h0;
    go(3'h0);
    {mmu_enable, chk_l1_desc} = {2'h3, 32'h61};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_DOM_PAGE, 4'h3, 0));
    {domain_access_control, chk_perm_fail} = {32'hFFFF_FF7F, 1'b1};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_PERM_PAGE, 4'h3, 0));
    chk_l1_desc = 32'h462;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_PERM_SEC, 4'h3, 0));
    domain_access_control = 32'hFFFF_FFFF;
    go(3'h0);
    {chk_perm_fail, chk_walk_needed, chk_walk_abort, chk_walk_slverr} = 4'h7;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_EXT_L1, 4'h0, 1));
    {chk_walk_abort_l2, chk_walk_slverr, chk_l1_desc} = {2'h2, 32'h1};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_EXT_L2, 4'h0, 0));
    {chk_walk_abort, chk_walk_abort_l2, chk_fetch, chk_l1_desc} = {3'h1, 32'h0};
    go(3'h2);
    rg(0, 3'h1, 0, cw(mfc_pkg::CODE_TRANS_SEC, 4'h0, 0));
    rg(0, 3'h3, 0, a);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_EXT_L2, 4'h0, 0));
    {chk_fetch, chk_dcache_maint} = 2'h1;
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_TRANS_SEC, 4'h0, 0));
    rg(0, 3'h2, 0, a);
    rg(0, 3'h3, 0, b);
    {chk_dcache_maint, chk_icache_maint, chk_l1_desc, chk_l2_desc} = {2'h1, 32'h1, 32'h0};
    go(3'h1);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_ICMO, 4'h0, 0));
    rg(0, 3'h1, 0, cw(mfc_pkg::CODE_TRANS_PAGE, 4'h0, 0));
    rg(0, 3'h2, 0, a);
    rg(0, 3'h3, 0, b);
    {chk_icache_maint, chk_walk_needed, chk_l1_desc, chk_l2_desc} = {2'h0, 32'h402, 32'h12};
    {monitor_debug_enable, lat, ev} = {1'b1, 2'h2, 7'h10};
    go(3'h0);
    note.push_back(32'h5);
    tick(4);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_DEBUG, 4'h0, 0));
    rg(0, 3'h4, 0, a);
    {monitor_debug_enable, ev} = {1'b0, 7'h48};
    go(3'h0);
    tick(4);
    {external_abort_trap, ev} = {1'b1, 7'h05};
    go(3'h0);
    note.push_back(32'h5);
    tick(4);
    rg(0, 3'h0, 1, cw(mfc_pkg::CODE_EXT_IMPREC, 4'h0, 1));
    rg(0, 3'h2, 1, 32'h0);
    rg(0, 3'h0, 0, cw(mfc_pkg::CODE_DEBUG, 4'h0, 0));
    {chk_secure, chk_walk_needed, walk_disable_upper} = 4'hF;
    go(3'h1);
    rg(0, 3'h0, 1, cw(mfc_pkg::CODE_TRANS_SEC, 4'h0, 0));
    {chk_walk_needed, ev} = {1'b0, 7'h47};
    go(3'h0);
    note.push_back(32'h2);
    tick(4);
    rg(0, 3'h1, 1, cw(mfc_pkg::CODE_EXT_PREC, 4'h0, 1));
    rg(0, 3'h3, 1, a);
    rg(0, 3'h0, 1, cw(mfc_pkg::CODE_TRANS_SEC, 4'h0, 0));
    ev = 7'h0;
    rg(1, 3'h1, 1, 32'h0000_1405);
    rg(0, 3'h1, 1, 32'h0000_1405);
    rg(0, 3'h7, 0, 32'h0);
    wrap_up();
  end
endmodule

bind mfc_fault_unit mfc_checker mfc_checker_inst (.*);
